// file: rtl/slb_pkg.sv
// Package for the self-test LED and beeper reporter: codes, timing and state types.
// Assumes one 10 MHz system clock and a self-test sequencer on the same clock.
// Summary of operation
// - While testing, LEDs show a code for the current test state.
// - Passing test turns all LEDs off and boot scanning starts at once.
// - On failure, LEDs finally show only the highest priority failure code.
// - If fitted, beeper sounds code bits 6..0, MSB first, one second each.
// - Without any failure the beeper stays silent throughout.
// - Checksum failure shows risk prompt, waits for return key without timeout.
// - Other failures show wait prompt and time out after one minute.
// - Unattended, an expired wait boots the first system found.
// - Return key during the wait stops beeping and cancels the wait.
// - Return key during the wait selects attended mode, no automatic boot.
// - Upper bits 00: progress state, lower six bits the state number.
// - Upper bits 01: required device missing or no bus acknowledge.
// - Upper bits 10: device found but failed its test.
// - Special codes outrank every other failure.
// - Device field 00 with failure number: miscellaneous, highest category.
// - Device field 01 with peripheral number: medium priority.
// - Device field with bit 5 set: plug-in card, lowest priority.
`default_nettype none

package slb_pkg;

    // Timing
    localparam int unsigned CLK_HZ        = 10_000_000;
    localparam int unsigned BEEP_BIT_MS   = 1000;
    localparam int unsigned BEEP_BIT_CYC  = BEEP_BIT_MS * (CLK_HZ / 1000);
    localparam int unsigned WAIT_S        = 60;
    localparam int unsigned WAIT_CYC      = WAIT_S * CLK_HZ;

    // Code layout
    localparam int unsigned CAT_MSB       = 7;
    localparam int unsigned CAT_LSB       = 6;
    localparam int unsigned GRP_MSB       = 5;
    localparam int unsigned GRP_LSB       = 4;
    localparam int unsigned BEEP_MSB      = 6;
    localparam logic [1:0]  CAT_STATE     = 2'h0;
    localparam logic [1:0]  CAT_MISSING   = 2'h1;
    localparam logic [1:0]  CAT_FAILING   = 2'h2;
    localparam logic [1:0]  GRP_MISC      = 2'h0;
    localparam logic [1:0]  GRP_PERIPH    = 2'h1;

    // Priority ranks
    localparam logic [1:0]  RANK_SPECIAL  = 2'h3;
    localparam logic [1:0]  RANK_MISC     = 2'h2;
    localparam logic [1:0]  RANK_PERIPH   = 2'h1;
    localparam logic [1:0]  RANK_CARD     = 2'h0;

    // Reset and pass values
    localparam logic [7:0]  LED_RESET     = 8'h00;
    localparam logic [7:0]  LED_PASS      = 8'h00;

    typedef enum logic [2:0] {
        ST_RUN,
        ST_WAIT_KEY,
        ST_WAIT_MIN,
        ST_BOOT
    } slb_st_t;

    typedef struct packed {
        logic       valid;
        logic       special;
        logic       checksum;
        logic [7:0] code;
    } slb_fail_t;

    typedef struct packed {
        slb_st_t     st;
        logic [7:0]  led;
        logic [7:0]  fcode;
        logic [1:0]  frank;
        logic        fany;
        logic        fcks;
        logic [31:0] wait_cnt;
        logic [31:0] bit_cnt;
        logic [2:0]  bit_idx;
        logic        beep_on;
        logic        tone_hi;
        logic        attended;
        logic        boot_go;
        logic        auto_boot;
        logic        p_risk;
        logic        p_wait;
        logic [2:0]  key_sy;
        logic [1:0]  fit_sy;
    } slb_state_t;

endpackage

`default_nettype wire

// file: rtl/slb_reporter.sv
// Self-test result reporter: LED display, serial beep code and post-test wait.
// Assumes progress and failure strobes come from the sequencer on clk_sys_i;
// the return key and beeper strap are asynchronous pins.
`default_nettype none

module slb_reporter #(
    parameter int unsigned BIT_CYC  = slb_pkg::BEEP_BIT_CYC,
    parameter int unsigned WAIT_CYC = slb_pkg::WAIT_CYC
) (
    // Clock and reset
    input  wire logic              clk_sys_i,
    input  wire logic              rst_i,
    // Self-test sequencer
    input  wire logic              state_load_i,
    input  wire logic [5:0]        state_num_i,
    input  wire slb_pkg::slb_fail_t fail_i,
    input  wire logic              test_done_i,
    // Pins
    input  wire logic              return_key_i,
    input  wire logic              beeper_fitted_i,
    // Display and beeper
    output logic [7:0]             led_o,
    output logic                   tone_en_o,
    output logic                   tone_high_o,
    // Prompts and boot hand-over
    output logic                   prompt_risk_o,
    output logic                   prompt_wait_o,
    output logic                   boot_scan_o,
    output logic                   attended_o,
    output logic                   auto_boot_o
);

    slb_pkg::slb_state_t q;
    slb_pkg::slb_state_t d;
    logic                key_press;
    logic                fit;
    logic [1:0]          new_rank;

    // Ranking by special flag and device field; within one rank the earliest failure is kept
    function automatic logic [1:0] rank_of(input slb_pkg::slb_fail_t f);
        logic [1:0] r;
        if (f.special) begin
            r = slb_pkg::RANK_SPECIAL;
        end else if (f.code[slb_pkg::GRP_MSB]) begin
            r = slb_pkg::RANK_CARD;
        end else if (f.code[slb_pkg::GRP_MSB:slb_pkg::GRP_LSB] == slb_pkg::GRP_MISC) begin
            r = slb_pkg::RANK_MISC;
        end else begin
            r = slb_pkg::RANK_PERIPH;
        end
        return r;
    endfunction

    assign new_rank  = rank_of(fail_i);
    assign key_press = q.key_sy[1] & ~q.key_sy[2];
    assign fit       = q.fit_sy[1];

    always_comb begin
        d         = q;
        d.boot_go = 1'b0;
        // Pins only reach logic through the second stage
        d.key_sy  = {q.key_sy[1:0], return_key_i};
        d.fit_sy  = {q.fit_sy[0], beeper_fitted_i};

        if (q.beep_on) begin
            if (q.bit_cnt == 32'(BIT_CYC - 1)) begin
                d.bit_cnt = '0;
                if (q.bit_idx == 3'h0) begin
                    d.beep_on = 1'b0;
                    d.tone_hi = 1'b0;
                end else begin
                    d.bit_idx = q.bit_idx - 3'h1;
                    d.tone_hi = q.fcode[d.bit_idx];
                end
            end else begin
                d.bit_cnt = q.bit_cnt + 32'h1;
            end
        end

        unique case (q.st)
            slb_pkg::ST_RUN: begin
                if (state_load_i) begin
                    d.led = {slb_pkg::CAT_STATE, state_num_i};
                end
                if (fail_i.valid && (!q.fany || new_rank > q.frank)) begin
                    d.fcode = fail_i.code;
                    d.frank = new_rank;
                    d.fcks  = fail_i.checksum;
                    d.fany  = 1'b1;
                end
                if (test_done_i) begin
                    if (!q.fany) begin
                        d.led       = slb_pkg::LED_PASS;
                        d.boot_go   = 1'b1;
                        d.auto_boot = ~q.attended;
                        d.st        = slb_pkg::ST_BOOT;
                    end else begin
                        d.led     = q.fcode;
                        d.beep_on = fit;
                        d.tone_hi = fit & q.fcode[slb_pkg::BEEP_MSB];
                        d.bit_idx = 3'(slb_pkg::BEEP_MSB);
                        d.bit_cnt = '0;
                        d.wait_cnt = '0;
                        if (q.fcks) begin
                            d.p_risk = 1'b1;
                            d.st     = slb_pkg::ST_WAIT_KEY;
                        end else begin
                            d.p_wait = 1'b1;
                            d.st     = slb_pkg::ST_WAIT_MIN;
                        end
                    end
                end
            end
            slb_pkg::ST_WAIT_KEY: begin
                if (key_press) begin
                    d.beep_on   = 1'b0;
                    d.tone_hi   = 1'b0;
                    d.attended  = 1'b1;
                    d.p_risk    = 1'b0;
                    d.boot_go   = 1'b1;
                    d.auto_boot = 1'b0;
                    d.st        = slb_pkg::ST_BOOT;
                end
            end
            slb_pkg::ST_WAIT_MIN: begin
                if (key_press) begin
                    d.beep_on   = 1'b0;
                    d.tone_hi   = 1'b0;
                    d.p_wait    = 1'b0;
                    d.boot_go   = 1'b1;
                    d.attended  = 1'b1;
                    d.auto_boot = 1'b0;
                    d.st        = slb_pkg::ST_BOOT;
                end else if (q.wait_cnt == 32'(WAIT_CYC - 1)) begin
                    d.p_wait    = 1'b0;
                    d.boot_go   = 1'b1;
                    d.auto_boot = ~q.attended;
                    d.st        = slb_pkg::ST_BOOT;
                end else begin
                    d.wait_cnt = q.wait_cnt + 32'h1;
                end
            end
            slb_pkg::ST_BOOT: begin
                d.led = q.led;
            end
            default: begin
                d.st = slb_pkg::ST_RUN;
            end
        endcase
    end

    // Beeping after a timeout may run on into boot; ST_BOOT ignores the key, so it plays to the end
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            q     <= '0;
            q.st  <= slb_pkg::ST_RUN;
            q.led <= slb_pkg::LED_RESET;
        end else begin
            q <= d;
        end
    end

    assign led_o         = q.led;
    assign tone_en_o     = q.beep_on;
    assign tone_high_o   = q.tone_hi;
    assign prompt_risk_o = q.p_risk;
    assign prompt_wait_o = q.p_wait;
    assign boot_scan_o   = q.boot_go;
    assign attended_o    = q.attended;
    assign auto_boot_o   = q.auto_boot;

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    AST_PROGRESS_LED: assert property (
        q.st == slb_pkg::ST_RUN && state_load_i && !test_done_i
        |=> led_o == {2'h0, $past(state_num_i)})
        else $error("Progress code not shown");

    AST_PASS_DARK: assert property (
        q.st == slb_pkg::ST_RUN && test_done_i && !q.fany
        |=> led_o == 8'h00 && boot_scan_o && !prompt_wait_o)
        else $error("Pass did not go dark and boot");

    AST_FAIL_SHOW: assert property (
        q.st == slb_pkg::ST_RUN && test_done_i && q.fany
        |=> led_o == $past(q.fcode) && !boot_scan_o)
        else $error("Failure code not shown");

    AST_BEEP_FIRST: assert property (
        q.st == slb_pkg::ST_RUN && test_done_i && q.fany && fit
        |=> tone_en_o && tone_high_o == $past(q.fcode[6]) && q.bit_idx == 3'h6)
        else $error("Beep did not start with bit six");

    AST_BIT_HOLD: assert property (
        tone_en_o && q.bit_cnt != 32'(BIT_CYC - 1) && !key_press
        |=> $stable(q.bit_idx) && $stable(tone_high_o))
        else $error("Beep bit changed early");

    AST_SILENT: assert property (
        !q.fany |-> !tone_en_o)
        else $error("Beeper sounded without failure");

    AST_RISK_STALL: assert property (
        q.st == slb_pkg::ST_WAIT_KEY && !key_press
        |=> q.st == slb_pkg::ST_WAIT_KEY && prompt_risk_o && !boot_scan_o)
        else $error("Checksum wait left without key");

    AST_TIMEOUT: assert property (
        q.st == slb_pkg::ST_WAIT_MIN && q.wait_cnt == 32'(WAIT_CYC - 1) && !key_press
        |=> boot_scan_o && !prompt_wait_o)
        else $error("Minute wait did not end");

    AST_UNATT_BOOT: assert property (
        q.st == slb_pkg::ST_WAIT_MIN && q.wait_cnt == 32'(WAIT_CYC - 1) && !key_press && !q.attended
        |=> auto_boot_o)
        else $error("Unattended boot not requested");

    AST_KEY_STOP: assert property (
        q.st == slb_pkg::ST_WAIT_MIN && key_press
        |=> !tone_en_o && boot_scan_o ##1 !boot_scan_o)
        else $error("Key did not stop beep and wait");

    AST_KEY_ATTEND: assert property (
        (q.st == slb_pkg::ST_WAIT_MIN || q.st == slb_pkg::ST_WAIT_KEY) && key_press
        |=> attended_o && !auto_boot_o)
        else $error("Key did not select attended mode");

    AST_SPECIAL_RANK: assert property (
        q.st == slb_pkg::ST_RUN && fail_i.valid && fail_i.special
        |=> q.frank == slb_pkg::RANK_SPECIAL && q.fany)
        else $error("Special code not ranked highest");

    AST_HOLD_LED: assert property (
        q.st == slb_pkg::ST_BOOT |=> $stable(led_o))
        else $error("Display changed after hand-over");

endmodule // slb_reporter

`default_nettype wire

// file: tb/slb_operator.sv
// Operator model: straps the beeper, presses the return key, listens to tones.
// Assumes the bench clock and the reporter's tone outputs.
`default_nettype none

module slb_operator #(
    parameter int unsigned BIT_CYC = 4
) (
    // Clock and reset
    input  wire logic clk_sys_i,
    input  wire logic rst_i,
    // Bench commands
    input  wire logic press_i,
    input  wire logic fitted_i,
    // Reporter side
    input  wire logic tone_en_i,
    input  wire logic tone_high_i,
    output logic      return_key_o,
    output logic      beeper_fitted_o,
    output logic [6:0] heard_o,
    output var int    heard_n_o
);
    timeunit 1ns;
    timeprecision 1ns;

    int cnt;

    assign beeper_fitted_o = fitted_i;

    // Switch reads low when released; a press lasts long enough for the synchroniser
    initial return_key_o = 1'b0;
    always @(posedge press_i) begin
        return_key_o <= 1'b1;
        repeat (5) @(negedge clk_sys_i);
        return_key_o <= 1'b0;
    end

    // Sample mid-bit, so edges of the tone never race the sample
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            cnt       <= 0;
            heard_n_o <= 0;
            heard_o   <= 7'h00;
        end else if (tone_en_i) begin
            cnt <= cnt + 1;
            if (cnt % BIT_CYC == BIT_CYC / 2) begin
                heard_o   <= {heard_o[5:0], tone_high_i};
                heard_n_o <= heard_n_o + 1;
            end
        end
    end
endmodule // slb_operator

`default_nettype wire

// file: tb/slb_reporter_test.sv
// Self-checking bench for the self-test reporter with shortened beep and wait counts.
// Assumes slb_operator stands in for the person at the console.
`default_nettype none

`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end

module slb_reporter_test;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int unsigned BIT = 4;
    localparam int unsigned WT  = 100;

    logic clk, rst, ld, done, press, fit, key, fit_pin, tone_seen;
    logic [5:0] num;
    slb_pkg::slb_fail_t fl;
    logic [7:0] led;
    logic tone, hi, p_risk, p_wait, boot, att, auto_b;
    logic [6:0] heard;
    int heard_n, fails, cmp_count, n;

    slb_reporter #(.BIT_CYC(BIT), .WAIT_CYC(WT)) slb_reporter_i (
        .clk_sys_i(clk), .rst_i(rst), .state_load_i(ld), .state_num_i(num), .fail_i(fl),
        .test_done_i(done), .return_key_i(key), .beeper_fitted_i(fit_pin), .led_o(led),
        .tone_en_o(tone), .tone_high_o(hi), .prompt_risk_o(p_risk), .prompt_wait_o(p_wait),
        .boot_scan_o(boot), .attended_o(att), .auto_boot_o(auto_b));

    slb_operator #(.BIT_CYC(BIT)) slb_operator_i (
        .clk_sys_i(clk), .rst_i(rst), .press_i(press), .fitted_i(fit), .tone_en_i(tone),
        .tone_high_i(hi), .return_key_o(key), .beeper_fitted_o(fit_pin), .heard_o(heard),
        .heard_n_o(heard_n));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) tone_seen <= rst ? 1'b0 : (tone_seen | tone);

    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask

    task automatic do_reset(input logic f);
        fit = f;
        rst = 1'b1;
        cyc(3);
        rst = 1'b0;
        cyc(2);
    endtask

    task automatic load(input logic [5:0] s);
        ld  = 1'b1;
        num = s;
        cyc(1);
        ld = 1'b0;
        `CHK("led_state", {2'b00, s}, led)
    endtask

    task automatic fail(input logic [7:0] c, input logic sp, input logic ck);
        fl = '{1'b1, sp, ck, c};
        cyc(1);
        fl = '0;
    endtask

    task automatic finish_test();
        done = 1'b1;
        cyc(1);
        done = 1'b0;
    endtask

    task automatic wait_boot(input int mx);
        n = 0;
        while (boot !== 1'b1 && n < mx) begin
            cyc(1);
            n++;
        end
    endtask

    task automatic push_key();
        press = 1'b1;
        cyc(1);
        press = 1'b0;
    endtask

    task automatic t_pass();
        do_reset(1'b1);
        load(6'h15);
        load(6'h2a);
        cyc(3);
        `CHK("led_hold", 8'h2a, led)
        finish_test();
        `CHK("led_off", 8'h00, led)
        `CHK("boot_now", 1'b1, boot)
        `CHK("auto_pass", 1'b1, auto_b)
        ld  = 1'b1;
        num = 6'h3f;
        cyc(30);
        ld = 1'b0;
        `CHK("led_after", 8'h00, led)
        `CHK("silent", 1'b0, tone_seen)
        $display("test pass_flow done");
    endtask

    task automatic t_timeout();
        do_reset(1'b1);
        load(6'h07);
        fail(8'ha3, 1'b0, 1'b0);
        fail(8'h92, 1'b0, 1'b0);
        fail(8'h81, 1'b0, 1'b0);
        fail(8'h42, 1'b0, 1'b0);
        fail(8'hbf, 1'b0, 1'b0);
        finish_test();
        `CHK("led_top", 8'h81, led)
        `CHK("prompt_wait", 1'b1, p_wait)
        `CHK("tone_first", 2'b10, {tone, hi})
        wait_boot(WT + 5);
        `CHK("boot_late", 1'b1, boot && n == WT)
        `CHK("wait_clear", 1'b0, p_wait)
        `CHK("auto_boot", 1'b1, auto_b)
        `CHK("unattended", 1'b0, att)
        `CHK("heard_n", 7, heard_n)
        `CHK("heard", 7'h01, heard)
        `CHK("tone_end", 1'b0, tone)
        `CHK("led_kept", 8'h81, led)
        $display("test timeout_flow done");
    endtask

    task automatic t_key();
        do_reset(1'b1);
        fail(8'h45, 1'b0, 1'b0);
        fail(8'h01, 1'b1, 1'b0);
        fail(8'h81, 1'b0, 1'b0);
        finish_test();
        `CHK("led_special", 8'h01, led)
        cyc(6);
        push_key();
        wait_boot(8);
        `CHK("key_boot", 1'b1, boot)
        `CHK("tone_stop", 1'b0, tone)
        `CHK("attended", 2'b10, {att, auto_b})
        `CHK("beep_cut", 1'b1, heard_n < 7)
        $display("test key_abort done");
    endtask

    task automatic t_missing();
        do_reset(1'b0);
        fail(8'ha3, 1'b0, 1'b0);
        fail(8'h52, 1'b0, 1'b0);
        fail(8'h6b, 1'b0, 1'b0);
        finish_test();
        `CHK("led_missing", 8'h52, led)
        `CHK("wait_shown", 2'b01, {p_risk, p_wait})
        push_key();
        wait_boot(8);
        `CHK("abort_boot", 4'b1100, {boot, att, auto_b, p_wait})
        $display("test missing_flow done");
    endtask

    task automatic t_checksum();
        do_reset(1'b0);
        fail(8'ha3, 1'b0, 1'b0);
        fail(8'h0e, 1'b1, 1'b1);
        finish_test();
        `CHK("prompts", 2'b10, {p_risk, p_wait})
        wait_boot(WT + 20);
        `CHK("no_timeout", 1'b0, boot)
        `CHK("no_beeper", 1'b0, tone_seen)
        push_key();
        wait_boot(8);
        `CHK("risk_boot", 1'b1, boot)
        `CHK("risk_clear", 1'b0, p_risk)
        `CHK("risk_att", 1'b1, att)
        $display("test checksum_flow done");
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        rst   = 1'b1;
        fit   = 1'b1;
        ld    = 1'b0;
        num   = 6'h00;
        fl    = '0;
        done  = 1'b0;
        press = 1'b0;
        cyc(3);
        t_pass();
        t_timeout();
        t_key();
        t_missing();
        t_checksum();
        complete_run();
    end

    // Whole run is well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        complete_run();
    end
endmodule // slb_reporter_test

`default_nettype wire
